// *** design/alert_status_bank.sv ***
// sticky communication and balancing alert registers with status frame
// assumes link decoders and balancing engine pulse events on mclk
// How it works
// - up-port check failure in link mode sets bit 15 of interface alerts.
// - down-port check failure sets bit 14 only in dual link config 11.
// - up-port coding violation in link mode sets bit 13.
// - down-port coding violation sets bit 12 only in dual config.
// - up parity error sets bit 11; down parity sets bit 10 dual only.
// - misrouted writes or host commands in dual config set bit 9.
// - latched alerts clear only on written zero; written one keeps bit.
// - serial rw mismatch, nonzero read data or timeout set bit 7.
// - each serial frame returns five status bits in output bits 31:27.
// - zero write to bit 7 clears crc, rw and timeout errors.
// - frame without exactly 32 clocks sets bit 6 and status bit 1.
// - fast oscillator drift beyond 5% in serial mode latches bit 5; a zero write clears it only once resolved.
// - internal bus failure in serial mode sets bit 4 and status bit 1.
// - bit 2 is read-only OR of masked nine two-wire errors.
// - protected write during scan or balancing sets bit 0.
// - watchdog halt sets balancing bit 15 while timeout disable is zero.
// - thermal halt sets bit 14 if enabled; clear only after run ends.
// - calibration halt sets bit 13; clear only after run ends.
// - progress note sets bit 12 when enabled by note configuration.
// - normal or undervoltage completion sets bit 11.
// - balancing register at 0x4 uses bits 15:11, rest reserved zero.
// - fault register at 0x5 resets zero; 13:10 read-only, others w0c.
// - interface alert register sits at 0x3, read and write.
// - interface summary ORs interface bits; check errors have own summary.
`timescale 1ns/10ps
module alert_status_bank #(
  parameter int two_wire_width = alert_pkg::two_wire_width
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire logic                      slow_clk,
  // mode configuration
  input  wire logic                      link_type_select,
  input  wire logic [1:0]                link_port_config,
  // register access
  input  wire alert_pkg::reg_req_t       reg_req,
  output logic [15:0]                    rdata_reg,
  // event sources
  input  wire alert_pkg::uart_ev_t       uart_ev,
  input  wire alert_pkg::spi_ev_t        spi_ev,
  input  wire alert_pkg::bal_ev_t        bal_ev,
  input  wire logic                      protected_write_busy,
  input  wire logic                      balance_active,
  input  wire logic                      balance_timeout_disable,
  input  wire logic                      balance_thermal_enable,
  input  wire logic                      balance_note_config,
  input  wire logic [two_wire_width-1:0] two_wire_status_bits,
  input  wire logic [two_wire_width-1:0] two_wire_alert_mask,
  input  wire logic [15:0]               fm1_set,
  // alert outputs
  output logic [4:0]                     frame_status_reg,
  output logic                           check_code_summary_reg,
  output logic                           interface_error_summary_reg
);
  if (two_wire_width != 9) begin : g_bad_width
    $error("two-wire width must be nine");
  end

  logic [15:0] intf_reg;
  logic [15:0] bal_reg;
  logic [15:0] fm1_reg;
  logic        crc_err_reg;
  logic        rw_err_reg;
  logic        transaction_timeout_error_reg;
  logic        drift;
  logic        drift_upd;
  logic        uart_mode;
  logic        dual_mode;
  logic        spi_mode;
  logic        wr_intf;
  logic        wr_bal;
  logic        wr_fm1;
  logic        rw_bad;
  logic        clk_bad;
  logic        two_wire_any;
  logic [15:0] intf_next;
  logic [15:0] bal_next;
  logic [15:0] intf_set;
  logic [15:0] bal_set;

  osc_drift_check u_osc (
    .mclk       (mclk),
    .nrst       (nrst),
    .slow_clk   (slow_clk),
    .drift_reg  (drift),
    .update_reg (drift_upd)
  );

  assign uart_mode = link_type_select;
  assign dual_mode = uart_mode &&
                     (link_port_config == alert_pkg::dual_cfg_code);
  assign spi_mode  = !link_type_select;
  assign wr_intf   = reg_req.wr && (reg_req.addr == alert_pkg::intf_offset);
  assign wr_bal    = reg_req.wr && (reg_req.addr == alert_pkg::bal_offset);
  assign wr_fm1    = reg_req.wr && (reg_req.addr == alert_pkg::fm1_offset);
  assign two_wire_any = |(two_wire_status_bits & two_wire_alert_mask);

  // serial frame checks
  assign rw_bad = spi_ev.frame_end &&
    ((spi_ev.frame_in[alert_pkg::spi_rw_bit] !=
      spi_ev.frame_in[alert_pkg::spi_rw_copy_bit]) ||
     (spi_ev.frame_in[alert_pkg::spi_rw_bit] &&
      spi_ev.frame_in[15:0] != 16'h0000));
  assign clk_bad = spi_ev.frame_end &&
    (spi_ev.clk_count != 6'(alert_pkg::spi_clock_count));

  always_comb begin
    intf_set = 16'h0000;
    intf_set[alert_pkg::up_check_bit]  = uart_mode && uart_ev.up_check;
    intf_set[alert_pkg::dn_check_bit]  = dual_mode && uart_ev.dn_check;
    intf_set[alert_pkg::up_coding_bit] = uart_mode && uart_ev.up_coding;
    intf_set[alert_pkg::dn_coding_bit] = dual_mode && uart_ev.dn_coding;
    intf_set[alert_pkg::up_parity_bit] = uart_mode && uart_ev.up_parity;
    intf_set[alert_pkg::dn_parity_bit] = dual_mode && uart_ev.dn_parity;
    intf_set[alert_pkg::dual_cmd_bit]  = dual_mode && uart_ev.dual_cmd;
    intf_set[alert_pkg::serial_sum_bit] = spi_mode &&
      (rw_bad || (spi_ev.frame_end && spi_ev.timeout));
    intf_set[alert_pkg::clk_count_bit] = spi_mode && clk_bad;
    intf_set[alert_pkg::fast_osc_bit]  = spi_mode && drift_upd && drift;
    intf_set[alert_pkg::int_bus_bit]   = spi_mode && spi_ev.bus_fail;
    intf_set[alert_pkg::rejected_bit]  =
      protected_write_busy && uart_ev.rejected;
  end

  always_comb begin
    intf_next = intf_reg;
    if (wr_intf) begin
      intf_next = intf_reg & reg_req.wdata;
      if (drift) begin
        intf_next[alert_pkg::fast_osc_bit] =
          intf_reg[alert_pkg::fast_osc_bit];
      end
    end
    intf_next = intf_next | intf_set;
    intf_next[alert_pkg::two_wire_bit] = two_wire_any;
    intf_next[8] = 1'b0;
    intf_next[3] = 1'b0;
    intf_next[1] = 1'b0;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      intf_reg <= alert_pkg::intf_reset;
    end else begin
      intf_reg <= intf_next;
    end
  end

  // hidden serial error latches behind the summary bit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      crc_err_reg <= 1'b0;
      rw_err_reg  <= 1'b0;
      transaction_timeout_error_reg  <= 1'b0;
    end else begin
      if (wr_intf && !reg_req.wdata[alert_pkg::serial_sum_bit]) begin
        crc_err_reg <= 1'b0;
        rw_err_reg  <= 1'b0;
        transaction_timeout_error_reg  <= 1'b0;
      end
      if (spi_mode && spi_ev.frame_end && spi_ev.crc_error) begin
        crc_err_reg <= 1'b1;
      end
      if (spi_mode && rw_bad) begin
        rw_err_reg <= 1'b1;
      end
      if (spi_mode && spi_ev.frame_end && spi_ev.timeout) begin
        transaction_timeout_error_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    bal_set = 16'h0000;
    bal_set[alert_pkg::bal_wdog_bit]  =
      bal_ev.watchdog && !balance_timeout_disable;
    bal_set[alert_pkg::bal_therm_bit] =
      bal_ev.thermal && balance_thermal_enable;
    bal_set[alert_pkg::bal_calib_bit] = bal_ev.calib;
    bal_set[alert_pkg::bal_note_bit]  =
      bal_ev.note && balance_note_config;
    bal_set[alert_pkg::bal_done_bit]  = bal_ev.done;
  end

  always_comb begin
    bal_next = bal_reg;
    if (wr_bal) begin
      bal_next = bal_reg & reg_req.wdata;
      if (balance_active) begin
        bal_next[alert_pkg::bal_therm_bit] =
          bal_reg[alert_pkg::bal_therm_bit];
        bal_next[alert_pkg::bal_calib_bit] =
          bal_reg[alert_pkg::bal_calib_bit];
      end
    end
    bal_next = (bal_next | bal_set) & alert_pkg::bal_live_mask;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bal_reg <= alert_pkg::bal_reset;
    end else begin
      bal_reg <= bal_next;
    end
  end

  // fault monitor one layout only; its sources arrive in fm1_set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fm1_reg <= alert_pkg::fm1_reset;
    end else if (wr_fm1) begin
      fm1_reg <= ((fm1_reg & reg_req.wdata & ~alert_pkg::fm1_ro_mask) |
                  (fm1_set & alert_pkg::fm1_ro_mask) | fm1_set);
    end else begin
      fm1_reg <= (fm1_reg & ~alert_pkg::fm1_ro_mask) | fm1_set;
    end
  end

  // read port
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 16'h0000;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        alert_pkg::intf_offset: rdata_reg <= intf_reg;
        alert_pkg::bal_offset:  rdata_reg <= bal_reg;
        alert_pkg::fm1_offset:  rdata_reg <= fm1_reg;
        default:                rdata_reg <= 16'h0000;
      endcase
    end
  end

  // per-frame status breakdown and summaries
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frame_status_reg            <= 5'h00;
      check_code_summary_reg      <= 1'b0;
      interface_error_summary_reg <= 1'b0;
    end else begin
      frame_status_reg <= {crc_err_reg, rw_err_reg, transaction_timeout_error_reg,
        intf_reg[alert_pkg::clk_count_bit] |
        intf_reg[alert_pkg::fast_osc_bit] |
        intf_reg[alert_pkg::int_bus_bit], 1'b0};
      check_code_summary_reg <= intf_reg[alert_pkg::up_check_bit] |
        intf_reg[alert_pkg::dn_check_bit] | crc_err_reg;
      if (uart_mode) begin
        interface_error_summary_reg <= |intf_reg[13:9] |
          intf_reg[alert_pkg::rejected_bit] |
          intf_reg[alert_pkg::two_wire_bit];
      end else begin
        interface_error_summary_reg <= |intf_reg[7:4] |
          intf_reg[alert_pkg::rejected_bit] |
          intf_reg[alert_pkg::two_wire_bit];
      end
    end
  end
endmodule

// *** common/alert_pkg.sv ***
// alert status register bank: offsets, bit positions, reset values, carriers
// assumes a register access port driven by the device's own link decoder
package alert_pkg;
  localparam logic [7:0] intf_offset = 8'h03;
  localparam logic [7:0] bal_offset  = 8'h04;
  localparam logic [7:0] fm1_offset  = 8'h05;
  localparam logic [15:0] intf_reset = 16'h0000;
  localparam logic [15:0] bal_reset  = 16'h0000;
  localparam logic [15:0] fm1_reset  = 16'h0000;
  // interface alert bit positions
  localparam int up_check_bit   = 15;
  localparam int dn_check_bit   = 14;
  localparam int up_coding_bit  = 13;
  localparam int dn_coding_bit  = 12;
  localparam int up_parity_bit  = 11;
  localparam int dn_parity_bit  = 10;
  localparam int dual_cmd_bit   = 9;
  localparam int serial_sum_bit = 7;
  localparam int clk_count_bit  = 6;
  localparam int fast_osc_bit   = 5;
  localparam int int_bus_bit    = 4;
  localparam int two_wire_bit   = 2;
  localparam int rejected_bit   = 0;
  // balancing alert bit positions
  localparam int bal_wdog_bit   = 15;
  localparam int bal_therm_bit  = 14;
  localparam int bal_calib_bit  = 13;
  localparam int bal_note_bit   = 12;
  localparam int bal_done_bit   = 11;
  localparam logic [15:0] bal_live_mask = 16'hF800;
  // fault monitor one: read-only single-ended flags 13:10, rest w0c
  localparam logic [15:0] fm1_ro_mask   = 16'h3C00;
  localparam logic [1:0]  dual_cfg_code = 2'b11;
  localparam int spi_clock_count  = 32;
  localparam int spi_rw_bit       = 31;
  localparam int spi_rw_copy_bit  = 3;
  // oscillator check: fast clocks per two slow cycles, 16MHz / 16384Hz
  localparam int osc_nominal      = 1953;
  localparam int osc_tol          = 97;
  localparam int two_wire_width   = 9;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic up_check;
    logic dn_check;
    logic up_coding;
    logic dn_coding;
    logic up_parity;
    logic dn_parity;
    logic dual_cmd;
    logic rejected;
  } uart_ev_t;

  typedef struct packed {
    logic        frame_end;
    logic [5:0]  clk_count;
    logic [31:0] frame_in;
    logic        crc_error;
    logic        timeout;
    logic        bus_fail;
  } spi_ev_t;

  typedef struct packed {
    logic watchdog;
    logic thermal;
    logic calib;
    logic note;
    logic done;
  } bal_ev_t;
endpackage

// *** design/osc_drift_check.sv ***
// oscillator drift check: counts fast clock edges per two slow cycles
// assumes mclk is the fast oscillator and slow_clk arrives asynchronously
`timescale 1ns/10ps
module osc_drift_check #(
  parameter int nominal = alert_pkg::osc_nominal,
  parameter int tol     = alert_pkg::osc_tol
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // slow oscillator level
  input  wire logic slow_clk,
  // result
  output logic      drift_reg,
  output logic      update_reg
);
  if (tol >= nominal || nominal + tol > 4094) begin : g_bad_window
    $error("bad drift window");
  end

  logic       sync1_reg;
  logic       sync2_reg;
  logic       sync3_reg;
  logic       half_reg;
  logic [11:0] count_reg;
  logic        rise;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= slow_clk;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~sync3_reg;

  // window of two slow cycles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      half_reg   <= 1'b0;
      count_reg  <= 12'h000;
      drift_reg  <= 1'b0;
      update_reg <= 1'b0;
    end else begin
      update_reg <= 1'b0;
      if (rise) begin
        half_reg <= ~half_reg;
      end
      if (rise && half_reg) begin
        count_reg  <= 12'h001;
        update_reg <= 1'b1;
        drift_reg  <= (count_reg < 12'(nominal - tol)) ||
                      (count_reg > 12'(nominal + tol));
      end else if (count_reg != 12'hFFF) begin
        count_reg <= count_reg + 12'h001;
      end
    end
  end
endmodule

// *** verif/host_reg_model.sv ***
// host side model issuing register strobes on the bank access port
// assumes one-cycle strobes taken on the rising edge of mclk
`timescale 1ns/10ps
module host_reg_model (
  // clock
  input  wire logic          mclk,
  // access port
  output alert_pkg::reg_req_t reg_req,
  input  wire logic [15:0]   rdata_reg
);
  initial reg_req = '0;

  task automatic put(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    reg_req <= '0;
  endtask

  task automatic get(input logic [7:0] a, output logic [15:0] d);
    put(1'b0, a, 16'h0000);
    @(posedge mclk);
    d = rdata_reg;
  endtask
endmodule

// *** verif/alert_bank_assertions.sv ***
// checker watching the alert bank ports
// assumes it is bound to alert_status_bank
`timescale 1ns/10ps
module alert_bank_checker #(
  parameter int two_wire_width = 9
) (
  // clock and reset
  input wire logic                      mclk,
  input wire logic                      nrst,
  input wire logic                      slow_clk,
  // mode and access
  input wire logic                      link_type_select,
  input wire logic [1:0]                link_port_config,
  input wire alert_pkg::reg_req_t       reg_req,
  input wire logic [15:0]               rdata_reg,
  // events and levels
  input wire alert_pkg::uart_ev_t       uart_ev,
  input wire alert_pkg::spi_ev_t        spi_ev,
  input wire alert_pkg::bal_ev_t        bal_ev,
  input wire logic                      protected_write_busy,
  input wire logic                      balance_active,
  input wire logic                      balance_timeout_disable,
  input wire logic                      balance_thermal_enable,
  input wire logic                      balance_note_config,
  input wire logic [two_wire_width-1:0] two_wire_status_bits,
  input wire logic [two_wire_width-1:0] two_wire_alert_mask,
  input wire logic [15:0]               fm1_set,
  // outputs
  input wire logic [4:0]                frame_status_reg,
  input wire logic                      check_code_summary_reg,
  input wire logic                      interface_error_summary_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_parity_to_summary: assert property (
    link_type_select && uart_ev.up_parity |-> ##2
    interface_error_summary_reg) else $error("parity alert lost");
  a_check_to_summary: assert property (
    link_type_select && uart_ev.up_check |-> ##2
    check_code_summary_reg) else $error("check alert lost");
  a_clock_count_status: assert property (
    !link_type_select && spi_ev.frame_end && spi_ev.clk_count != 6'h20
    |-> ##2 frame_status_reg[1]) else $error("clock count not flagged");
  a_crc_to_status: assert property (
    !link_type_select && spi_ev.frame_end && spi_ev.crc_error |-> ##2
    (frame_status_reg[4] && check_code_summary_reg))
    else $error("crc not reported");
  a_status_low_zero: assert property (
    frame_status_reg[0] == 1'b0) else $error("status bit0 set");
  a_unmapped_read_zero: assert property (
    reg_req.rd && !(reg_req.addr inside {8'h03, 8'h04, 8'h05})
    |=> rdata_reg == 16'h0000) else $error("unmapped read not zero");
  a_bal_reserved_zero: assert property (
    reg_req.rd && reg_req.addr == 8'h04 |=> rdata_reg[10:0] == 11'h000)
    else $error("reserved bits set");
  a_live_fault_bits: assert property (
    reg_req.rd && reg_req.addr == 8'h05 && $stable(fm1_set) |=>
    rdata_reg[13:10] == $past(fm1_set[13:10]))
    else $error("single-ended flags wrong");
  a_two_wire_or: assert property (
    reg_req.rd && reg_req.addr == 8'h03 && $stable(two_wire_status_bits)
    && $stable(two_wire_alert_mask) |=> rdata_reg[2] ==
    |($past(two_wire_status_bits) & $past(two_wire_alert_mask)))
    else $error("two-wire summary wrong");
endmodule

bind alert_status_bank alert_bank_checker #(
  .two_wire_width(two_wire_width)
) u_alert_bank_checker (
  .mclk(mclk), .nrst(nrst), .slow_clk(slow_clk),
  .link_type_select(link_type_select), .link_port_config(link_port_config),
  .reg_req(reg_req), .rdata_reg(rdata_reg), .uart_ev(uart_ev),
  .spi_ev(spi_ev), .bal_ev(bal_ev),
  .protected_write_busy(protected_write_busy),
  .balance_active(balance_active),
  .balance_timeout_disable(balance_timeout_disable),
  .balance_thermal_enable(balance_thermal_enable),
  .balance_note_config(balance_note_config),
  .two_wire_status_bits(two_wire_status_bits),
  .two_wire_alert_mask(two_wire_alert_mask), .fm1_set(fm1_set),
  .frame_status_reg(frame_status_reg),
  .check_code_summary_reg(check_code_summary_reg),
  .interface_error_summary_reg(interface_error_summary_reg)
);

// *** verif/alert_status_bank_tb.sv ***
// self-checking bench for the alert status bank
// assumes the host model drives the register access port
`timescale 1ns/10ps
module alert_status_bank_tb;
  logic mclk = 0, nrst = 0, slow_clk = 0, link_type_select = 1;
  logic [1:0] link_port_config = 2'b11;
  alert_pkg::reg_req_t reg_req;
  alert_pkg::uart_ev_t uart_ev = '0;
  alert_pkg::spi_ev_t spi_ev = '0;
  alert_pkg::bal_ev_t bal_ev = '0;
  logic protected_write_busy = 1, balance_active = 0;
  logic balance_timeout_disable = 0, balance_thermal_enable = 1;
  logic balance_note_config = 1;
  logic [8:0] two_wire_status_bits = '0, two_wire_alert_mask = '0;
  logic [15:0] fm1_set = '0, rdata_reg, rd;
  logic [4:0] frame_status_reg;
  logic check_code_summary_reg, interface_error_summary_reg;
  wire [15:0] sums = {14'h0, check_code_summary_reg,
                      interface_error_summary_reg};
  int n_errors = 0, checks_done = 0, half = 488, sc = 0;

  always #12.5 mclk = ~mclk;
  // slow oscillator: 4*half mclk cycles per two slow cycles
  always @(posedge mclk) begin
    if (sc >= half - 1) begin
      sc <= 0;
      slow_clk <= ~slow_clk;
    end else begin
      sc <= sc + 1;
    end
  end

  alert_status_bank u_alert_status_bank (.mclk, .nrst, .slow_clk,
    .link_type_select, .link_port_config, .reg_req, .rdata_reg, .uart_ev,
    .spi_ev, .bal_ev, .protected_write_busy, .balance_active,
    .balance_timeout_disable, .balance_thermal_enable, .balance_note_config,
    .two_wire_status_bits, .two_wire_alert_mask, .fm1_set,
    .frame_status_reg, .check_code_summary_reg,
    .interface_error_summary_reg);
  host_reg_model u_host_reg_model (.mclk, .reg_req, .rdata_reg);

  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host_reg_model.put(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    u_host_reg_model.get(a, rd);
    cmp(rd, e);
  endtask
  // k: 0 link events, 1 balancing events, 2 internal bus failure
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge mclk);
    if (k == 0) uart_ev <= v;
    else if (k == 1) bal_ev <= v[4:0];
    else spi_ev.bus_fail <= 1'b1;
    @(posedge mclk);
    uart_ev <= '0;
    bal_ev <= '0;
    spi_ev <= '0;
    tick(2);
  endtask
  task automatic frame(input logic [5:0] n, input logic [31:0] d,
    input logic [1:0] ct, input logic [4:0] es, input logic [15:0] er);
    wr(8'h03, 16'h0000);
    @(posedge mclk);
    spi_ev <= {1'b1, n, d, ct[1], ct[0], 1'b0};
    @(posedge mclk);
    spi_ev <= '0;
    tick(2);
    cmp({11'h0, frame_status_reg}, {11'h0, es});
    rchk(8'h03, er);
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    print_verdict;
  end

  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rchk(8'h03, 16'h0000);
    rchk(8'h04, 16'h0000);
    rchk(8'h05, 16'h0000);
    wr(8'h0F, 16'hFFFF);
    rchk(8'h0F, 16'h0000);
    for (int i = 0; i < 8; i++) pulse(0, 8'h80 >> i);
    rchk(8'h03, 16'hFE01);
    cmp(sums, 16'h0003);
    wr(8'h03, 16'hFFFF);
    rchk(8'h03, 16'hFE01);
    wr(8'h03, 16'hF7FF);
    rchk(8'h03, 16'hF601);
    wr(8'h03, 16'h0000);
    rchk(8'h03, 16'h0000);
    cmp(sums, 16'h0000);
    link_port_config <= 2'b00;
    protected_write_busy <= 1'b0;
    pulse(0, 8'h57);
    rchk(8'h03, 16'h0000);
    two_wire_status_bits <= 9'h1FF;
    tick(2);
    rchk(8'h03, 16'h0000);
    two_wire_alert_mask <= 9'h100;
    tick(2);
    wr(8'h03, 16'h0000);
    rchk(8'h03, 16'h0004);
    two_wire_status_bits <= 9'h0FF;
    tick(2);
    rchk(8'h03, 16'h0000);
    link_type_select <= 1'b0;
    pulse(0, 8'h80);
    tick(6000);
    wr(8'h03, 16'h0000);
    rchk(8'h03, 16'h0000);
    frame(6'd31, 32'h0, 2'b00, 5'h02, 16'h0040);
    frame(6'd33, 32'h0, 2'b00, 5'h02, 16'h0040);
    frame(6'd32, 32'h80000000, 2'b00, 5'h08, 16'h0080);
    frame(6'd32, 32'h80000009, 2'b00, 5'h08, 16'h0080);
    frame(6'd32, 32'h80000008, 2'b00, 5'h08, 16'h0080);
    frame(6'd32, 32'h00000000, 2'b00, 5'h00, 16'h0000);
    frame(6'd32, 32'h0, 2'b01, 5'h04, 16'h0080);
    frame(6'd32, 32'h0, 2'b10, 5'h10, 16'h0000);
    wr(8'h03, 16'hFF7F);
    tick(3);
    cmp(sums, 16'h0000);
    pulse(2, 8'h00);
    rchk(8'h03, 16'h0010);
    cmp({11'h0, frame_status_reg}, 16'h0002);
    cmp(sums, 16'h0001);
    wr(8'h03, 16'h0000);
    half <= 244;
    tick(6000);
    wr(8'h03, 16'h0000);
    rchk(8'h03, 16'h0020);
    half <= 488;
    tick(6000);
    wr(8'h03, 16'h0000);
    rchk(8'h03, 16'h0000);
    balance_active <= 1'b1;
    pulse(1, 8'h1F);
    rchk(8'h04, 16'hF800);
    wr(8'h04, 16'h0000);
    rchk(8'h04, 16'h6000);
    balance_active <= 1'b0;
    wr(8'h04, 16'h0000);
    rchk(8'h04, 16'h0000);
    balance_timeout_disable <= 1'b1;
    balance_thermal_enable <= 1'b0;
    balance_note_config <= 1'b0;
    pulse(1, 8'h1F);
    rchk(8'h04, 16'h2800);
    fm1_set <= 16'hFFFF;
    tick(2);
    wr(8'h05, 16'h0000);
    rchk(8'h05, 16'hFFFF);
    fm1_set <= 16'h0000;
    tick(2);
    wr(8'h05, 16'hFFFF);
    rchk(8'h05, 16'hC3FF);
    wr(8'h05, 16'h0000);
    rchk(8'h05, 16'h0000);
    print_verdict;
  end
endmodule
